// ### lis_frame_buf.sv
// Two-entry word buffer with valid and ready on both sides
`default_nettype none
module lis_frame_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  lis_stream_if.snk wr,
  lis_stream_if.src rd
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } lis_buf_s;
  lis_buf_s st_ff;
  lis_buf_s nxt_st;
  logic push;
  logic pop;

  assign wr.ready = (st_ff.cnt != (PW+1)'(DEPTH));
  assign rd.valid = (st_ff.cnt != '0);
  assign rd.data = st_ff.mem[st_ff.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = wr.data;
      nxt_st.wp = (st_ff.wp == PW'(DEPTH-1)) ? '0 : PW'(st_ff.wp + 1'b1);
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == PW'(DEPTH-1)) ? '0 : PW'(st_ff.rp + 1'b1);
    end
    nxt_st.cnt = (PW+1)'(st_ff.cnt + (PW+1)'(push) - (PW+1)'(pop));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : lis_frame_buf
`default_nettype wire

// ### lis_link_init.sv
// Transmit link initialization sequencer: code group sync, lane alignment, data
// Behaviour
// - First sync code group 5..7 frames after boundary
// - Lane alignment starts 5..7 frames after boundary
// - Sample data starts at least 5 frames after boundary
// - Lane alignment lasts four multi-frames
// - Lane rate 1 to 7.4 Gb/s, both lane modes
// - One sample per converter per frame
// - Frames per multi-frame configurable, default 32, minimums
`default_nettype none
module lis_link_init #(
  parameter int FRAME_DIV = 1,
  parameter int TD = lis_pkg::TD_FRAMES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sysref,
  input wire logic sync_request_n,
  input wire logic dual_lane,
  input wire logic [lis_pkg::K_W-1:0] k_frames,
  input wire logic [lis_pkg::SAMP_W-1:0] samp_a,
  input wire logic [lis_pkg::SAMP_W-1:0] samp_b,
  output logic samp_take,
  output logic lmfc_boundary,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_kind,
  output logic [lis_pkg::DATA_W-1:0] out_data
);
  typedef struct packed {
    lis_pkg::lis_st_e st;
    logic [7:0] div;
    logic [lis_pkg::K_W-1:0] cnt;
    logic [lis_pkg::K_W:0] kval;
    logic lane;
    logic [2:0] mf;
    logic [2:0] low;
    logic sref_d;
    logic sref_pend;
  } lis_seq_s;

  lis_seq_s st_ff;
  lis_seq_s nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic tick;
  logic [lis_pkg::K_W:0] k_lo;
  logic [lis_pkg::K_W:0] k_sel;
  logic [1:0] kind;
  logic [lis_pkg::DATA_W-1:0] word;

  lis_stream_if #(.W(lis_pkg::WORD_W)) buf_in ();
  lis_stream_if #(.W(lis_pkg::WORD_W)) buf_out ();

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Frame tick stalls while the buffer is full, and stays low while reset holds
  assign tick = rst_n && (st_ff.div == 8'h00) && buf_in.ready;
  assign lmfc_boundary = tick && (st_ff.cnt == '0);

  always_comb begin
    nxt_st = st_ff;
    k_lo = dual_lane ? (lis_pkg::K_W+1)'(lis_pkg::K_MIN_TWO_LANE) : (lis_pkg::K_W+1)'(lis_pkg::K_MIN_ONE_LANE);
    k_sel = {1'b0, k_frames};
    if (k_sel < k_lo) begin
      k_sel = k_lo;
    end
    if (k_sel > (lis_pkg::K_W+1)'(lis_pkg::K_MAX)) begin
      k_sel = (lis_pkg::K_W+1)'(lis_pkg::K_MAX);
    end
    kind = lis_pkg::KIND_CGS;
    word = {lis_pkg::K28_5, lis_pkg::K28_5, lis_pkg::K28_5, lis_pkg::K28_5};
    nxt_st.sref_d = sysref;
    if (sysref && !st_ff.sref_d) begin
      nxt_st.sref_pend = 1'b1;
    end
    if (st_ff.div != 8'h00 || tick) begin
      nxt_st.div = (st_ff.div == 8'(FRAME_DIV - 1)) ? 8'h00 : 8'(st_ff.div + 8'h01);
    end
    if (tick) begin
      if (st_ff.sref_pend || st_ff.cnt == lis_pkg::K_W'(st_ff.kval - 1'b1)) begin
        nxt_st.cnt = '0;
        nxt_st.sref_pend = sysref && !st_ff.sref_d;
      end else begin
        nxt_st.cnt = lis_pkg::K_W'(st_ff.cnt + 1'b1);
      end
      if (sync_request_n) begin
        nxt_st.low = '0;
      end else if (st_ff.low != 3'(lis_pkg::RESYNC_HOLD)) begin
        nxt_st.low = 3'(st_ff.low + 3'h1);
      end
      case (st_ff.st)
        lis_pkg::LIS_IDLE: begin
          nxt_st.kval = k_sel;
          nxt_st.lane = dual_lane;
          if (st_ff.cnt == lis_pkg::K_W'(TD)) begin
            nxt_st.st = lis_pkg::LIS_CGS;
          end
        end
        lis_pkg::LIS_CGS: begin
          if (sync_request_n && st_ff.cnt == '0) begin
            nxt_st.st = lis_pkg::LIS_ALIGN;
          end
        end
        lis_pkg::LIS_ALIGN: begin
          if (st_ff.cnt == lis_pkg::K_W'(TD)) begin
            nxt_st.st = lis_pkg::LIS_ILA;
            nxt_st.mf = '0;
          end
        end
        lis_pkg::LIS_ILA: begin
          if (st_ff.cnt == lis_pkg::K_W'(TD)) begin
            if (st_ff.mf == 3'(lis_pkg::ILA_MF - 1)) begin
              nxt_st.st = lis_pkg::LIS_DATA;
            end else begin
              nxt_st.mf = 3'(st_ff.mf + 3'h1);
            end
          end
        end
        lis_pkg::LIS_DATA: begin
        end
        default: begin
          nxt_st.st = lis_pkg::LIS_IDLE;
        end
      endcase
      if (st_ff.st != lis_pkg::LIS_IDLE && st_ff.st != lis_pkg::LIS_CGS
          && nxt_st.low == 3'(lis_pkg::RESYNC_HOLD)) begin
        nxt_st.st = lis_pkg::LIS_IDLE;
      end
    end
    if (nxt_st.st == lis_pkg::LIS_ILA) begin
      kind = lis_pkg::KIND_ILA;
      word = {8'h00, 5'h00, nxt_st.mf, 2'h0, nxt_st.cnt, 8'h00};
    end else if (nxt_st.st == lis_pkg::LIS_DATA) begin
      kind = lis_pkg::KIND_DATA;
      word = {samp_a, samp_b};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{st: lis_pkg::LIS_IDLE, kval: (lis_pkg::K_W+1)'(lis_pkg::K_DEF), default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign buf_in.valid = tick && nxt_st.st != lis_pkg::LIS_IDLE;
  assign buf_in.data = {kind, word};
  assign samp_take = tick && nxt_st.st == lis_pkg::LIS_DATA;

  lis_frame_buf #(.W(lis_pkg::WORD_W), .DEPTH(lis_pkg::BUF_DEPTH)) u_buf (
    .clk(mclk),
    .rst_n(rst_n),
    .wr(buf_in),
    .rd(buf_out)
  );

  assign out_valid = buf_out.valid;
  assign buf_out.ready = out_ready;
  assign out_kind = buf_out.data[lis_pkg::WORD_W-1 -: 2];
  assign out_data = buf_out.data[lis_pkg::DATA_W-1:0];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_cgs_start;
    (st_ff.st == lis_pkg::LIS_CGS && $past(st_ff.st) == lis_pkg::LIS_IDLE)
      |-> ($past(st_ff.cnt) >= lis_pkg::K_W'(lis_pkg::TD_MIN))
      && ($past(st_ff.cnt) <= lis_pkg::K_W'(lis_pkg::TD_MAX));
  endproperty
  a_cgs_start: assert property (p_cgs_start) else $error("sync codes started off the boundary window");

  property p_ila_start;
    (st_ff.st == lis_pkg::LIS_ILA && $past(st_ff.st) != lis_pkg::LIS_ILA)
      |-> ($past(st_ff.cnt) >= lis_pkg::K_W'(lis_pkg::TD_MIN))
      && ($past(st_ff.cnt) <= lis_pkg::K_W'(lis_pkg::TD_MAX));
  endproperty
  a_ila_start: assert property (p_ila_start) else $error("alignment started off the boundary window");

  property p_data_start;
    (st_ff.st == lis_pkg::LIS_DATA && $past(st_ff.st) != lis_pkg::LIS_DATA)
      |-> $past(st_ff.cnt) >= lis_pkg::K_W'(lis_pkg::TD_MIN);
  endproperty
  a_data_start: assert property (p_data_start) else $error("data started too early after boundary");

  property p_ila_len;
    (st_ff.st == lis_pkg::LIS_DATA && $past(st_ff.st) != lis_pkg::LIS_DATA)
      |-> $past(st_ff.mf) == 3'(lis_pkg::ILA_MF - 1);
  endproperty
  a_ila_len: assert property (p_ila_len) else $error("alignment length not four multi-frames");

  property p_lane_stable;
    $changed(st_ff.lane) |-> $past(st_ff.st) == lis_pkg::LIS_IDLE;
  endproperty
  a_lane_stable: assert property (p_lane_stable) else $error("lane mode changed outside idle");

  property p_sample_frame;
    samp_take |-> buf_in.valid && buf_in.data[lis_pkg::WORD_W-1 -: 2] == lis_pkg::KIND_DATA
      && buf_in.data[lis_pkg::DATA_W-1:0] == {samp_a, samp_b};
  endproperty
  a_sample_frame: assert property (p_sample_frame) else $error("sample not carried in its frame");

  property p_k_range;
    st_ff.kval <= (lis_pkg::K_W+1)'(lis_pkg::K_MAX) && st_ff.kval >= (st_ff.lane ?
      (lis_pkg::K_W+1)'(lis_pkg::K_MIN_TWO_LANE) : (lis_pkg::K_W+1)'(lis_pkg::K_MIN_ONE_LANE));
  endproperty
  a_k_range: assert property (p_k_range) else $error("multi-frame length out of range");

  property p_cgs_hold;
    (st_ff.st == lis_pkg::LIS_CGS && tick && !sync_request_n) |=> st_ff.st == lis_pkg::LIS_CGS;
  endproperty
  a_cgs_hold: assert property (p_cgs_hold) else $error("left sync codes while requested");

  c_reach_data: cover property (st_ff.st == lis_pkg::LIS_ILA ##1 st_ff.st == lis_pkg::LIS_DATA);
  c_resync: cover property (st_ff.st == lis_pkg::LIS_DATA ##1 st_ff.st == lis_pkg::LIS_IDLE);
  c_stall: cover property (buf_in.valid && !buf_in.ready);
endmodule : lis_link_init
`default_nettype wire

// ### lis_link_init_tb.sv
// Self-checking bench for the link initialization sequencer
`default_nettype none
module lis_link_init_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, resetn = 1'b0, sysref = 1'b0, dual_lane = 1'b0, want_sync = 1'b1, stall = 1'b0;
  logic [5:0] k_frames = 6'h05;
  logic [15:0] samp_a = 16'h0000, samp_b = 16'hFFFF;
  wire logic sync_request_n, out_ready, samp_take, lmfc_boundary, out_valid;
  wire logic [1:0] out_kind;
  wire logic [31:0] out_data;
  int n_mismatch = 0, tests_run = 0, cyc = 0, since = 0, per = 0, ila_n = 0, ila_last = 0, td_seen = 0;
  logic [1:0] last_kind = 2'h3;
  logic [31:0] expq[$];
  always #2.5 mclk = ~mclk;
  lis_link_init uut (.mclk(mclk), .resetn(resetn), .sysref(sysref), .sync_request_n(sync_request_n),
    .dual_lane(dual_lane), .k_frames(k_frames), .samp_a(samp_a), .samp_b(samp_b), .samp_take(samp_take),
    .lmfc_boundary(lmfc_boundary), .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
    .out_data(out_data));
  lis_rx_model rx (.mclk(mclk), .lmfc_boundary(lmfc_boundary), .want_sync(want_sync), .stall(stall),
    .out_ready(out_ready), .sync_request_n(sync_request_n));
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] td_ok(input int lo, input int hi);
    return 32'(td_seen >= lo + 1 && td_seen <= hi + 1);
  endfunction : td_ok
  task wait_kind(input logic [1:0] k);
    while (last_kind !== k) @(negedge mclk);
  endtask : wait_kind
  // Monitor samples settled values at the rising edge
  always @(posedge mclk) begin
    if (lmfc_boundary === 1'b1) begin
      per = since + 1;
      since = 0;
    end else since++;
    if (samp_take === 1'b1) expq.push_back({samp_a, samp_b});
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (out_kind !== last_kind) begin
        td_seen = since;
        ila_last = ila_n;
        ila_n = 0;
      end
      last_kind = out_kind;
      if (out_kind === lis_pkg::KIND_ILA) ila_n++;
      if (out_kind === lis_pkg::KIND_DATA) check(out_data, expq.pop_front());
      if (out_kind === lis_pkg::KIND_CGS) check(out_data, {4{lis_pkg::K28_5}});
    end
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  always @(negedge mclk) begin
    samp_a <= samp_a + 16'h0001;
    samp_b <= samp_b - 16'h0001;
  end
  task t_cgs;
    wait_kind(lis_pkg::KIND_CGS);
    check(td_ok(lis_pkg::TD_MIN, lis_pkg::TD_MAX), 32'h1);
    repeat (30) @(negedge mclk);
    check(32'(last_kind), 32'(lis_pkg::KIND_CGS));
    check(32'(per), 32'(lis_pkg::K_MIN_ONE_LANE));
  endtask : t_cgs
  task t_sysref;
    sysref = 1'b1;
    // Edge is caught at the next rising edge, the count is cleared one tick later
    repeat (2) @(negedge mclk);
    check(32'(lmfc_boundary), 32'h1);
    @(negedge mclk);
    sysref = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : t_sysref
  task t_align(input int k);
    want_sync <= 1'b0;
    wait_kind(lis_pkg::KIND_ILA);
    check(td_ok(lis_pkg::TD_MIN, lis_pkg::TD_MAX), 32'h1);
    check(32'(per), 32'(k));
    wait_kind(lis_pkg::KIND_DATA);
    check(32'(ila_last), 32'(lis_pkg::ILA_MF * k));
    check(32'(td_seen >= lis_pkg::TD_MIN + 1), 32'h1);
  endtask : t_align
  task t_stall;
    stall <= 1'b1;
    repeat (8) @(negedge mclk);
    stall <= 1'b0;
    repeat (20) @(negedge mclk);
    check(32'(expq.size() <= 3), 32'h1);
  endtask : t_stall
  task t_resync;
    k_frames = 6'h03;
    dual_lane = 1'b1;
    want_sync <= 1'b1;
    wait_kind(lis_pkg::KIND_CGS);
    check(td_ok(lis_pkg::TD_MIN, lis_pkg::TD_MAX), 32'h1);
    repeat (40) @(negedge mclk);
    t_align(lis_pkg::K_MIN_TWO_LANE);
  endtask : t_resync
  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    t_cgs();
    t_sysref();
    t_align(lis_pkg::K_MIN_ONE_LANE);
    t_stall();
    t_resync();
    repeat (10) @(negedge mclk);
    give_verdict();
  end
endmodule : lis_link_init_tb
`default_nettype wire

// ### lis_pkg.sv
// Constants and types shared by the link initialization sequencer
`default_nettype none
package lis_pkg;
  localparam int TD_FRAMES = 6;
  localparam int TD_MIN = 5;
  localparam int TD_MAX = 7;
  localparam int ILA_MF = 4;
  localparam int RESYNC_HOLD = 4;
  localparam int K_W = 6;
  localparam int K_DEF = 32;
  localparam int K_MAX = 32;
  localparam int K_MIN_ONE_LANE = 9;
  localparam int K_MIN_TWO_LANE = 17;
  localparam int LANE_RATE_MIN_MBPS = 1000;
  localparam int LANE_RATE_MAX_MBPS = 7400;
  localparam int SAMP_W = 16;
  localparam int DATA_W = 2 * SAMP_W;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [1:0] KIND_CGS = 2'h0;
  localparam logic [1:0] KIND_ILA = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam int WORD_W = DATA_W + 2;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [2:0] {LIS_IDLE, LIS_CGS, LIS_ALIGN, LIS_ILA, LIS_DATA} lis_st_e;
endpackage : lis_pkg
`default_nettype wire

// ### lis_rx_model.sv
// Behavioural link receiver: ready control and sync request timing
`default_nettype none
module lis_rx_model (
  input wire logic mclk,
  input wire logic lmfc_boundary,
  input wire logic want_sync,
  input wire logic stall,
  output logic out_ready,
  output logic sync_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  logic past_b = 1'b0;
  initial begin
    out_ready = 1'b1;
    sync_request_n = 1'b0;
  end
  always @(negedge mclk) begin
    out_ready <= !stall;
    past_b <= lmfc_boundary;
    hold <= sync_request_n ? 0 : hold + 1;
    // Change level only just after a boundary, and release after a long enough hold
    if (past_b && (want_sync || hold >= lis_pkg::RESYNC_HOLD)) begin
      sync_request_n <= !want_sync;
    end
  end
endmodule : lis_rx_model
`default_nettype wire

// ### lis_stream_if.sv
// Valid/ready word stream between sequencer and buffer
`default_nettype none
interface lis_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lis_stream_if
`default_nettype wire
